//--- psr_exec.sv
// Execution datapath for register-pair and accumulator-rotate instructions
`timescale 1ns/1ps
module psr_exec (
	// Clock and reset
	input  wire logic                 i_sys_clk,
	input  wire logic                 i_nrst,
	// Instruction issue
	input  wire logic                 i_op_valid,
	input  wire logic [7:0]           i_opcode,
	output logic                      o_op_ready,
	output logic                      o_op_done,
	// Byte-wide stack memory
	output psr_pkg::psr_mem_req_s     o_mem,
	output logic                      o_mem_req,
	input  wire logic [7:0]           i_mem_rdata,
	// Architectural state
	output psr_pkg::psr_regs_s        o_regs,
	output logic [7:0]                o_condition_flag_byte
);
	import psr_pkg::*;

	//----------------------------------------
	// Decode
	//----------------------------------------
	function automatic logic is_op(input logic [7:0] op, input logic [7:0] pat);
		is_op = (op & PSR_OP_PUSH_MASK) == pat;
	endfunction : is_op

	wire logic [1:0] dec_psel  = i_opcode[5:4];
	wire logic       dec_push  = is_op(i_opcode, PSR_OP_PUSH);
	wire logic       dec_pop   = is_op(i_opcode, PSR_OP_POP);
	wire logic       dec_padd  = is_op(i_opcode, PSR_OP_PADD);
	wire logic       dec_pinc  = is_op(i_opcode, PSR_OP_PINC);
	wire logic       dec_pdec  = is_op(i_opcode, PSR_OP_PDEC);
	wire logic       dec_swtop = i_opcode == PSR_OP_SWTOP;
	wire logic       dec_mem   = dec_push | dec_pop | dec_swtop;

	psr_regs_s  r;
	psr_state_e state;
	logic [1:0] op_psel;
	logic       op_push, op_pop;
	logic [7:0] tmp;
	// Old byte at stack pointer plus one, kept for the swap's last step
	logic [7:0] hold;

	//----------------------------------------
	// Pair selection helpers
	//----------------------------------------
	function automatic logic [15:0] pair_get(input psr_regs_s q, input logic [1:0] psel);
		case (psel)
			PSR_PSEL_BC: pair_get = {q.b, q.c};
			PSR_PSEL_DE: pair_get = {q.d, q.e};
			PSR_PSEL_HL: pair_get = {q.h, q.l};
			default:   pair_get = q.sp;
		endcase
	endfunction : pair_get

	function automatic logic [7:0] flag_pack(input psr_flags_s f);
		logic [7:0] v;
		v = PSR_FB_ONES;
		v[PSR_FB_S]  = f.s;
		v[PSR_FB_Z]  = f.z;
		v[PSR_FB_AC] = f.ac;
		v[PSR_FB_P]  = f.p;
		v[PSR_FB_CY] = f.cy;
		flag_pack = v;
	endfunction : flag_pack

	// Push source pair: flag byte first, accumulator second for code 11
	wire logic [15:0] push_src = (op_psel == PSR_PSEL_FA) ? {flag_pack(r.fl), r.a}
	                                                      : pair_get(r, op_psel);
	wire logic [15:0] hl       = {r.h, r.l};
	wire logic [15:0] dad_pair = pair_get(r, dec_psel);
	wire logic [16:0] dad_sum  = {1'b0, hl} + {1'b0, dad_pair};
	wire logic [15:0] inc_val  = dad_pair + PSR_ONE16;
	wire logic [15:0] dec_val  = dad_pair - PSR_ONE16;
	wire logic [15:0] sp_m1    = r.sp - PSR_ONE16;
	wire logic [15:0] sp_m2    = r.sp - PSR_TWO16;
	wire logic [15:0] sp_p1    = r.sp + PSR_ONE16;

	//----------------------------------------
	// Memory port, one byte per cycle
	//----------------------------------------
	assign o_op_ready = (state == PSR_IDLE);
	always_comb begin
		o_mem     = '0;
		o_mem_req = 1'b0;
		case (state)
			PSR_ST1: begin
				o_mem_req = 1'b1;
				o_mem.wr  = op_push;
				o_mem.addr = op_push ? sp_m1 : r.sp;
				o_mem.wdata = push_src[15:8];
			end
			PSR_ST2: begin
				o_mem_req = 1'b1;
				o_mem.wr  = op_push;
				o_mem.addr = op_push ? sp_m2 : sp_p1;
				o_mem.wdata = push_src[7:0];
			end
			PSR_ST3: begin
				o_mem_req = 1'b1;
				o_mem.wr  = 1'b1;
				o_mem.addr = r.sp;
				o_mem.wdata = r.l;
			end
			PSR_ST4: begin
				o_mem_req = 1'b1;
				o_mem.wr  = 1'b1;
				o_mem.addr = sp_p1;
				o_mem.wdata = r.h;
			end
			default: begin
				o_mem_req = 1'b0;
			end
		endcase
	end

	//----------------------------------------
	// Load a pair from two bytes
	//----------------------------------------
	function automatic psr_regs_s pair_put(input psr_regs_s q, input logic [1:0] psel,
	                                       input logic [15:0] v);
		psr_regs_s n;
		n = q;
		case (psel)
			PSR_PSEL_BC: {n.b, n.c} = v;
			PSR_PSEL_DE: {n.d, n.e} = v;
			PSR_PSEL_HL: {n.h, n.l} = v;
			default: begin
				n.a     = v[7:0];
				n.fl.s  = v[8 + PSR_FB_S];
				n.fl.z  = v[8 + PSR_FB_Z];
				n.fl.ac = v[8 + PSR_FB_AC];
				n.fl.p  = v[8 + PSR_FB_P];
				n.fl.cy = v[8 + PSR_FB_CY];
			end
		endcase
		pair_put = n;
	endfunction : pair_put

	//----------------------------------------
	// Next-state and register update
	//----------------------------------------
	psr_regs_s  next_r;
	psr_state_e next_state;
	logic       done;
	always_comb begin
		next_r     = r;
		next_state = state;
		done       = 1'b0;
		case (state)
			PSR_IDLE: begin
				if (i_op_valid) begin
					if (dec_mem) begin
						next_state = PSR_ST1;
					end else begin
						done = 1'b1;
						if (dec_padd) begin
							{next_r.h, next_r.l} = dad_sum[15:0];
							next_r.fl.cy = dad_sum[16];
						end else if (dec_pinc) begin
							next_r = (dec_psel == PSR_PSEL_FA) ? r : pair_put(r, dec_psel, inc_val);
							if (dec_psel == PSR_PSEL_FA) next_r.sp = inc_val;
						end else if (dec_pdec) begin
							next_r = (dec_psel == PSR_PSEL_FA) ? r : pair_put(r, dec_psel, dec_val);
							if (dec_psel == PSR_PSEL_FA) next_r.sp = dec_val;
						end else if (i_opcode == PSR_OP_SWDE) begin
							{next_r.h, next_r.l, next_r.d, next_r.e} = {r.d, r.e, r.h, r.l};
						end else if (i_opcode == PSR_OP_LDSP) begin
							next_r.sp = hl;
						end else if (i_opcode == PSR_OP_ROTL) begin
							next_r.a = {r.a[6:0], r.a[7]};
							next_r.fl.cy = r.a[7];
						end else if (i_opcode == PSR_OP_ROTR) begin
							next_r.a = {r.a[0], r.a[7:1]};
							next_r.fl.cy = r.a[0];
						end else if (i_opcode == PSR_OP_ROTLC) begin
							next_r.a = {r.a[6:0], r.fl.cy};
							next_r.fl.cy = r.a[7];
						end
					end
				end
			end
			PSR_ST1: begin
				next_state = PSR_ST2;
			end
			PSR_ST2: begin
				if (op_push) begin
					next_state = PSR_IDLE;
					done = 1'b1;
					next_r.sp = sp_m2;
				end else if (op_pop) begin
					next_state = PSR_IDLE;
					done = 1'b1;
					next_r = pair_put(r, op_psel, {i_mem_rdata, tmp});
					next_r.sp = r.sp + PSR_TWO16;
				end else begin
					next_state = PSR_ST3;
				end
			end
			PSR_ST3: begin
				next_state = PSR_ST4;
			end
			PSR_ST4: begin
				next_state = PSR_IDLE;
				done = 1'b1;
				next_r.l = tmp;
				next_r.h = hold; // Bus carries a write now, not the old byte
			end
			default: begin
				next_state = PSR_IDLE;
			end
		endcase
	end

	// Captured byte: low pop byte or old stack-top byte for the swap
	wire logic [7:0] next_tmp = (state == PSR_ST1) ? i_mem_rdata :
	                            (state == PSR_ST2) ? i_mem_rdata : tmp;
	wire logic [7:0] keep_tmp = (state == PSR_ST2 && !op_pop && !op_push) ? tmp : next_tmp;
	// Stack-top swap reads SP into tmp in ST1, SP+1 into hold in ST2

	//----------------------------------------
	// State registers
	//----------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			state   <= PSR_IDLE;
			r       <= '0;
			op_psel <= PSR_PSEL_BC;
			op_push <= 1'b0;
			op_pop  <= 1'b0;
			tmp     <= 8'h00;
			hold    <= 8'h00;
			o_op_done <= 1'b0;
		end else begin
			state     <= next_state;
			r         <= next_r;
			tmp       <= keep_tmp;
			hold      <= (state == PSR_ST2) ? i_mem_rdata : hold;
			o_op_done <= done;
			if (state == PSR_IDLE && i_op_valid) begin
				op_psel <= dec_psel;
				op_push <= dec_push;
				op_pop  <= dec_pop;
			end
		end
	end

	// Swap writes the held high byte back into H at the final step
	assign o_regs = (state == PSR_IDLE) ? r : r;
	assign o_condition_flag_byte = flag_pack(r.fl);
endmodule : psr_exec

//--- psr_exec_checker.sv
// Checker: port-level assertions for the pair/rotate datapath
`timescale 1ns/1ps
module psr_exec_checker (
	// Clock, reset and issue
	input  wire logic                  i_sys_clk,
	input  wire logic                  i_nrst,
	input  wire logic                  i_op_valid,
	input  wire logic [7:0]            i_opcode,
	input  wire logic                  o_op_ready,
	input  wire logic                  o_op_done,
	// Memory and state
	input  wire psr_pkg::psr_mem_req_s o_mem,
	input  wire logic                  o_mem_req,
	input  wire psr_pkg::psr_regs_s    o_regs,
	input  wire logic [7:0]            o_condition_flag_byte
);
	import psr_pkg::*;
	logic [7:0] a_q;
	logic       cy_q;
	// Taken instruction decode
	wire        tk   = i_op_valid && o_op_ready;
	wire        push = tk && ((i_opcode & PSR_OP_PUSH_MASK) == PSR_OP_PUSH);
	wire        pop  = tk && ((i_opcode & PSR_OP_PUSH_MASK) == PSR_OP_POP);
	wire [15:0] sp   = o_regs.sp;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);
	// Accumulator and carry one cycle back
	always_ff @(posedge i_sys_clk) begin
		a_q  <= o_regs.a;
		cy_q <= o_regs.fl.cy;
	end
	a_push_order: assert property (push |=> o_mem_req && o_mem.wr
		&& o_mem.addr == $past(sp) - PSR_ONE16
		##1 o_mem_req && o_mem.wr && o_mem.addr == $past(sp, 2) - PSR_TWO16)
		else $error("push write order wrong");
	a_push_sp: assert property (push |-> ##3 o_op_done && sp == $past(sp, 3) - PSR_TWO16)
		else $error("push stack pointer wrong");
	a_pop_order: assert property (pop |=> o_mem_req && !o_mem.wr && o_mem.addr == $past(sp)
		##1 o_mem_req && !o_mem.wr && o_mem.addr == $past(sp, 2) + PSR_ONE16)
		else $error("pop read order wrong");
	a_flag_layout: assert property (o_condition_flag_byte == {o_regs.fl.s, o_regs.fl.z,
		1'b0, o_regs.fl.ac, 1'b0, o_regs.fl.p, 1'b1, o_regs.fl.cy})
		else $error("flag byte layout wrong");
	a_ldsp_copy: assert property (tk && i_opcode == PSR_OP_LDSP |=>
		sp == {o_regs.h, o_regs.l} && $stable({o_regs.h, o_regs.l}))
		else $error("stack pointer load wrong");
	a_swde_swap: assert property (tk && i_opcode == PSR_OP_SWDE |=>
		{o_regs.h, o_regs.l, o_regs.d, o_regs.e} == $past({o_regs.d, o_regs.e, o_regs.h, o_regs.l}))
		else $error("pair swap wrong");
	a_rotl_rot: assert property (tk && i_opcode == PSR_OP_ROTL |=>
		o_regs.a == {a_q[6:0], a_q[7]} && o_regs.fl.cy == a_q[7])
		else $error("left rotate wrong");
	a_rotlc_rot: assert property (tk && i_opcode == PSR_OP_ROTLC |=>
		o_regs.a == {a_q[6:0], cy_q} && o_regs.fl.cy == a_q[7])
		else $error("rotate via carry wrong");
	a_rotr_rot: assert property (tk && i_opcode == PSR_OP_ROTR |=>
		o_regs.a == {a_q[0], a_q[7:1]} && o_regs.fl.cy == a_q[0])
		else $error("right rotate wrong");
endmodule : psr_exec_checker
bind psr_exec psr_exec_checker i_psr_exec_checker (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
	.i_op_valid(i_op_valid), .i_opcode(i_opcode), .o_op_ready(o_op_ready),
	.o_op_done(o_op_done), .o_mem(o_mem), .o_mem_req(o_mem_req), .o_regs(o_regs),
	.o_condition_flag_byte(o_condition_flag_byte));

//--- psr_mem_model.sv
// Partner: byte-wide stack memory with combinational read
`timescale 1ns/1ps
module psr_mem_model (
	// Clock and request
	input  wire logic                  i_sys_clk,
	input  wire psr_pkg::psr_mem_req_s i_mem,
	input  wire logic                  i_mem_req,
	// Read data
	output logic [7:0]                 o_mem_rdata
);
	import psr_pkg::*;
	logic [7:0] mem [0:65535];
	logic [7:0] last = 8'h00;
	// Idle bus shows inverse of last byte, never a held value
	assign o_mem_rdata = (i_mem_req && !i_mem.wr) ? mem[i_mem.addr] : ~last;
	// One byte per request cycle
	always @(posedge i_sys_clk) begin
		if (i_mem_req && i_mem.wr) mem[i_mem.addr] <= i_mem.wdata;
		if (i_mem_req) last <= i_mem.wr ? i_mem.wdata : mem[i_mem.addr];
	end
endmodule : psr_mem_model

//--- psr_pkg.sv
// Package: constants, opcodes, flag layout and carriers for the pair/rotate datapath
package psr_pkg;
	//----------------------------------------
	// Pair select codes
	//----------------------------------------
	localparam logic [1:0] PSR_PSEL_BC = 2'h0;
	localparam logic [1:0] PSR_PSEL_DE = 2'h1;
	localparam logic [1:0] PSR_PSEL_HL = 2'h2;
	localparam logic [1:0] PSR_PSEL_FA = 2'h3;
	//----------------------------------------
	// Opcode fixed patterns
	//----------------------------------------
	localparam logic [7:0] PSR_OP_PUSH_MASK = 8'hCF;
	localparam logic [7:0] PSR_OP_PUSH      = 8'hC5;
	localparam logic [7:0] PSR_OP_POP       = 8'hC1;
	localparam logic [7:0] PSR_OP_PADD      = 8'h09;
	localparam logic [7:0] PSR_OP_PINC      = 8'h03;
	localparam logic [7:0] PSR_OP_PDEC      = 8'h0B;
	localparam logic [7:0] PSR_OP_SWDE      = 8'hEB;
	localparam logic [7:0] PSR_OP_SWTOP     = 8'hE3;
	localparam logic [7:0] PSR_OP_LDSP      = 8'hF9;
	localparam logic [7:0] PSR_OP_ROTL      = 8'h07;
	localparam logic [7:0] PSR_OP_ROTR      = 8'h0F;
	localparam logic [7:0] PSR_OP_ROTLC     = 8'h17;
	//----------------------------------------
	// Flag byte bit positions and constants
	//----------------------------------------
	localparam int PSR_FB_S  = 7;
	localparam int PSR_FB_Z  = 6;
	localparam int PSR_FB_AC = 4;
	localparam int PSR_FB_P  = 2;
	localparam int PSR_FB_CY = 0;
	localparam logic [7:0] PSR_FB_ONES = 8'h02; // Bit 1 fixed high
	localparam logic [15:0] PSR_ONE16 = 16'h0001;
	localparam logic [15:0] PSR_TWO16 = 16'h0002;
	//----------------------------------------
	// Carriers
	//----------------------------------------
	typedef struct packed {
		logic s;
		logic z;
		logic ac;
		logic p;
		logic cy;
	} psr_flags_s;
	typedef struct packed {
		logic [7:0] a, b, c, d, e, h, l;
		logic [15:0] sp;
		psr_flags_s fl;
	} psr_regs_s;
	typedef struct packed {
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} psr_mem_req_s;
	typedef enum logic [2:0] {
		PSR_IDLE = 3'b000,
		PSR_ST1  = 3'b001,
		PSR_ST2  = 3'b011,
		PSR_ST3  = 3'b010,
		PSR_ST4  = 3'b110
	} psr_state_e;
endpackage : psr_pkg

//--- testbench.sv
// Testbench: instruction sequences against the pair/rotate datapath
`timescale 1ns/1ps
module testbench;
	import psr_pkg::*;
	logic         i_sys_clk = 1'b0, i_nrst = 1'b0, i_op_valid = 1'b0;
	logic [7:0]   i_opcode  = 8'h00;
	logic         o_op_ready, o_op_done, o_mem_req;
	logic [7:0]   i_mem_rdata, o_condition_flag_byte;
	psr_mem_req_s o_mem;
	psr_regs_s    o_regs;
	int           n_mismatch = 0, cmp_count = 0;
	logic [7:0]   rop [5] = '{8'h07, 8'h0F, 8'h0F, 8'h17, 8'h17};
	logic [15:0]  raf [5] = '{16'h11D7, 16'h88D7, 16'h44D6, 16'h88D6, 16'h10D7};
	// Design and partner
	psr_exec i_psr_exec (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_op_valid(i_op_valid),
		.i_opcode(i_opcode), .o_op_ready(o_op_ready), .o_op_done(o_op_done), .o_mem(o_mem),
		.o_mem_req(o_mem_req), .i_mem_rdata(i_mem_rdata), .o_regs(o_regs),
		.o_condition_flag_byte(o_condition_flag_byte));
	psr_mem_model i_psr_mem_model (.i_sys_clk(i_sys_clk), .i_mem(o_mem),
		.i_mem_req(o_mem_req), .o_mem_rdata(i_mem_rdata));
	// Clock and watchdog
	initial forever #25 i_sys_clk = ~i_sys_clk;
	initial begin
		#50000;
		n_mismatch++;
		stop_test();
	end
	task stop_test;
		$display("mismatches %0d compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	task chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
		cmp_count++;
		if (got !== ex) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk
	// Issue one opcode, wait for its done pulse
	task op(input logic [7:0] code);
		int k;
		i_op_valid = 1'b1;
		i_opcode = code;
		@(posedge i_sys_clk);
		#2 i_op_valid = 1'b0;
		k = 0;
		while (o_op_done !== 1'b1 && k < 10) begin
			@(posedge i_sys_clk);
			#2 k++;
		end
		chk("done", 16'h0001, {15'h0000, o_op_done});
	endtask : op
	// Main sequence
	initial begin
		i_psr_mem_model.mem[16'h0000] = 8'h34;
		i_psr_mem_model.mem[16'h0001] = 8'h12;
		i_psr_mem_model.mem[16'h1234] = 8'h01;
		i_psr_mem_model.mem[16'h1235] = 8'h80;
		i_psr_mem_model.mem[16'h1236] = 8'h88;
		i_psr_mem_model.mem[16'h1237] = 8'hFF;
		repeat (10) @(posedge i_sys_clk);
		#2 i_nrst = 1'b1;
		chk("af", 16'h0002, {o_regs.a, o_condition_flag_byte});
		op(8'hE1);
		chk("hl", 16'h1234, {o_regs.h, o_regs.l});
		chk("sp", 16'h0002, o_regs.sp);
		op(8'hF9);
		chk("sp", 16'h1234, o_regs.sp);
		chk("hl", 16'h1234, {o_regs.h, o_regs.l});
		op(8'hC1);
		chk("bc", 16'h8001, {o_regs.b, o_regs.c});
		chk("af", 16'h0002, {o_regs.a, o_condition_flag_byte});
		op(8'hF1);
		chk("af", 16'h88D7, {o_regs.a, o_condition_flag_byte});
		chk("sp", 16'h1238, o_regs.sp);
		op(8'hF5);
		chk("m37", 16'hD788, {i_psr_mem_model.mem[16'h1237], i_psr_mem_model.mem[16'h1236]});
		chk("sp", 16'h1236, o_regs.sp);
		i_psr_mem_model.mem[16'h1234] = 8'h00;
		i_psr_mem_model.mem[16'h1235] = 8'h00;
		op(8'hC5);
		chk("m35", 16'h8001, {i_psr_mem_model.mem[16'h1235], i_psr_mem_model.mem[16'h1234]});
		chk("af", 16'h88D7, {o_regs.a, o_condition_flag_byte});
		op(8'hEB);
		chk("hlde", 16'h0000, {o_regs.h, o_regs.l});
		chk("de", 16'h1234, {o_regs.d, o_regs.e});
		op(8'hE3);
		chk("hl", 16'h8001, {o_regs.h, o_regs.l});
		chk("m35", 16'h0000, {i_psr_mem_model.mem[16'h1235], i_psr_mem_model.mem[16'h1234]});
		chk("sp", 16'h1234, o_regs.sp);
		op(8'h19);
		chk("hl", 16'h9235, {o_regs.h, o_regs.l});
		chk("af", 16'h88D6, {o_regs.a, o_condition_flag_byte});
		op(8'h09);
		chk("hl", 16'h1236, {o_regs.h, o_regs.l});
		chk("af", 16'h88D7, {o_regs.a, o_condition_flag_byte});
		op(8'h33);
		chk("sp", 16'h1235, o_regs.sp);
		op(8'h0B);
		chk("bc", 16'h8000, {o_regs.b, o_regs.c});
		chk("af", 16'h88D7, {o_regs.a, o_condition_flag_byte});
		for (int i = 0; i < 5; i++) begin
			op(rop[i]);
			chk("af", raf[i], {o_regs.a, o_condition_flag_byte});
		end
		stop_test();
	end
endmodule : testbench
